// ===== rtl/sfw_flash_seq.sv
// Program, erase, wrap and power-down command sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sfw_defines.svh"

// What this block does
// - Wrap setting: opcode, 24 dummies, one byte
// - Wrap applies only to quad reads
// - Keep wrap bits; lengths 8 to 64
// - Program and erase need write enable first
// - Program frame: opcode, address, data bytes
// - Program address wraps within the page
// - Only last 256 data bytes kept
// - Unsent page bytes stay unchanged
// - Program needs whole last data byte
// - Busy after valid frame; latch cleared
// - Protected targets are not written
// - Sector erase covers addressed sector
// - Erase needs exactly three address bytes
// - 32KB block erase covers its block
// - 64KB block erase covers its block
// - Chip erase: either opcode, alone
// - Chip erase only with no protection
// - Power-down after delay, opcode alone
// - In power-down only release is heard
// - Power-down refused while busy
// - Reset and deselect leave standby
// - Wrapped reads loop inside section
// - Release opcode exits power-down
module sfw_flash_seq
  import sfw_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `SFW_T_PP_US * `SFW_CLK_MHZ,
  parameter int unsigned SECTOR_CYCLES = `SFW_T_SE_US * `SFW_CLK_MHZ,
  parameter int unsigned BLOCK_CYCLES = `SFW_T_BE_US * `SFW_CLK_MHZ,
  parameter int unsigned CHIP_CYCLES = `SFW_T_CE_US * `SFW_CLK_MHZ,
  parameter logic [7:0] DEV_ID = 8'h5A
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic csN,
  input wire logic si,
  output logic soOut,
  output logic soOe,
  input wire logic [4:0] protectBits,
  output logic writeInProgress,
  output logic writeEnableLatch,
  output logic deepPowerDown,
  output logic wrapDisableBit,
  output logic [1:0] wrapLengthSel,
  output logic progValid,
  output logic [23:0] progAddr,
  output logic [7:0] progData,
  output logic eraseValid,
  output var sfw_erase_type eraseKind,
  output logic [23:0] eraseAddr,
  input wire logic readQuad,
  input wire logic readLoad,
  input wire logic [23:0] readStartAddr,
  input wire logic readStep,
  output logic [23:0] readAddr
);

  localparam int unsigned DP_CYCLES = `SFW_T_DP_US * `SFW_CLK_MHZ;

  // Top or bottom share of 64KB blocks: bit 3 picks the side, the low bits the size
  function automatic logic isProtected(input logic [23:0] a,
                                       input logic [4:0] bp);
    logic [3:0] cnt;
    logic [3:0] blk;
    cnt = 4'h0;
    blk = {1'b0, a[`SFW_BLOCK_POS +: 3]};
    if (bp[2:0] >= `SFW_BLOCK_HALF)
      cnt = `SFW_BLOCK_COUNT;
    else if (bp[2:0] != 3'h0)
      cnt = 4'h1 << (bp[2:0] - 3'h1);
    if (bp[3])
      isProtected = (blk < cnt);
    else
      isProtected = (blk >= (`SFW_BLOCK_COUNT - cnt));
  endfunction

  // Next read address, looping inside the selected section
  function automatic logic [23:0] readNext(input logic [23:0] a,
                                           input logic wrapOn,
                                           input logic [1:0] len);
    logic [7:0] m;
    logic [7:0] low;
    m = (`SFW_WRAP_BASE << len) - 8'h01;
    low = a[7:0] + 8'h01;
    if (wrapOn)
      readNext = {a[23:8], (a[7:0] & ~m) | (low & m)};
    else
      readNext = a + 24'h000001;
  endfunction

  // Frame end seen in the system domain
  logic csSync;
  logic csSeen_reg;
  logic csRise;

  // Link fields
  logic [7:0] lnkOp;
  logic [23:0] lnkAddr;
  logic [7:0] lnkLast;
  logic [2:0] lnkBitPos;
  logic [5:0] lnkBytes;
  logic [255:0] bufMask;
  logic [7:0] bufByte;

  // Control state
  sfw_state_type state_reg;
  logic [31:0] timer_reg;
  logic [7:0] progIdx_reg;
  logic [15:0] page_reg;
  logic wel_reg;
  logic dpd_reg;
  logic wrapDis_reg;
  logic [1:0] wrapLen_reg;
  logic [23:0] readAddr_reg;

  // Decoded requests
  logic onByte;
  logic cmdFree;
  logic isChipOp;
  logic isEraseOp;
  logic opWel;
  logic opWrd;
  logic opWrap;
  logic opProg;
  logic opErase;
  logic opChip;
  logic opDown;
  logic opRel;
  logic busy;
  sfw_erase_type kindNext;
  logic [23:0] eraseMask;
  logic [31:0] eraseCycles;

  sfw_sync u_cs_sync (
    .clk(clk_sys),
    .din(csN),
    .dout(csSync)
  );

  sfw_link_rx #(.DEV_ID(DEV_ID)) u_link (
    .sclk(sclk),
    .csN(csN),
    .si(si),
    .busySys(busy),
    .bufIdx(progIdx_reg),
    .opcode(lnkOp),
    .addr(lnkAddr),
    .lastByte(lnkLast),
    .bitPos(lnkBitPos),
    .byteCnt(lnkBytes),
    .bufMask(bufMask),
    .bufByte(bufByte),
    .soOut(soOut),
    .soOe(soOe)
  );

  // Link fields are static while deselected, so one edge is enough
  always_ff @(posedge clk_sys) begin
    if (!resetn)
      csSeen_reg <= 1'b1;
    else
      csSeen_reg <= csSync;
  end

  assign csRise = csSync & ~csSeen_reg;
  assign busy = (state_reg == SFW_PROG) || (state_reg == SFW_BUSY);

  always_comb begin
    onByte = (lnkBitPos == 3'h0);
    // Only standby takes new work; power-down hears release only
    cmdFree = csRise & onByte & (state_reg == SFW_IDLE) & ~dpd_reg;
    isChipOp = (lnkOp == `SFW_OP_CHIP_A) || (lnkOp == `SFW_OP_CHIP_B);
    isEraseOp = (lnkOp == `SFW_OP_SECTOR) || (lnkOp == `SFW_OP_BLOCK32) ||
                (lnkOp == `SFW_OP_BLOCK64);
    opWel = cmdFree & (lnkOp == `SFW_OP_WR_ENABLE) &
            (lnkBytes == `SFW_LEN_OPCODE);
    opWrd = cmdFree & (lnkOp == `SFW_OP_WR_DISABLE) &
            (lnkBytes == `SFW_LEN_OPCODE);
    opWrap = cmdFree & (lnkOp == `SFW_OP_WRAP_SET) &
             (lnkBytes == `SFW_LEN_WRAP);
    opProg = cmdFree & wel_reg & (lnkOp == `SFW_OP_PROGRAM) &
             (lnkBytes > `SFW_LEN_ADDR) &
             ~isProtected(lnkAddr, protectBits);
    opErase = cmdFree & wel_reg & isEraseOp &
              (lnkBytes == `SFW_LEN_ADDR) &
              ~isProtected(lnkAddr, protectBits);
    opChip = cmdFree & wel_reg & isChipOp &
             (lnkBytes == `SFW_LEN_OPCODE) &
             (protectBits[2:0] == 3'h0);
    opDown = cmdFree & (lnkOp == `SFW_OP_POWER_DOWN) &
             (lnkBytes == `SFW_LEN_OPCODE);
    // Release also ends a dummy-byte ID read; ignored while busy
    opRel = csRise & onByte & dpd_reg & (state_reg == SFW_IDLE) &
            (lnkOp == `SFW_OP_RELEASE) &
            (lnkBytes >= `SFW_LEN_OPCODE);
  end

  always_comb begin
    kindNext = SFW_ER_CHIP;
    eraseMask = 24'h000000;
    eraseCycles = CHIP_CYCLES;
    unique case (lnkOp)
      `SFW_OP_SECTOR: begin
        kindNext = SFW_ER_SECTOR;
        eraseMask = `SFW_SECTOR_MASK;
        eraseCycles = SECTOR_CYCLES;
      end
      `SFW_OP_BLOCK32: begin
        kindNext = SFW_ER_BLOCK32;
        eraseMask = `SFW_BLOCK32_MASK;
        eraseCycles = BLOCK_CYCLES;
      end
      `SFW_OP_BLOCK64: begin
        kindNext = SFW_ER_BLOCK64;
        eraseMask = `SFW_BLOCK64_MASK;
        eraseCycles = BLOCK_CYCLES;
      end
      default: begin
        kindNext = SFW_ER_CHIP;
        eraseMask = 24'h000000;
        eraseCycles = CHIP_CYCLES;
      end
    endcase
  end

  // Self-timed sequencer; reset lands in standby
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_reg <= SFW_IDLE;
      timer_reg <= 32'h0;
      progIdx_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        SFW_IDLE: begin
          progIdx_reg <= 8'h00;
          if (opProg) begin
            state_reg <= SFW_PROG;
          end else if (opErase || opChip) begin
            state_reg <= SFW_BUSY;
            timer_reg <= eraseCycles - 32'h1;
          end else if (opDown) begin
            state_reg <= SFW_DPWAIT;
            timer_reg <= DP_CYCLES - 32'h1;
          end
        end
        SFW_PROG: begin
          progIdx_reg <= progIdx_reg + 8'h01;
          if (progIdx_reg == 8'hFF) begin
            state_reg <= SFW_BUSY;
            timer_reg <= PROG_CYCLES - 32'h1;
          end
        end
        SFW_BUSY: begin
          if (timer_reg == 32'h0)
            state_reg <= SFW_IDLE;
          else
            timer_reg <= timer_reg - 32'h1;
        end
        SFW_DPWAIT: begin
          if (timer_reg == 32'h0)
            state_reg <= SFW_IDLE;
          else
            timer_reg <= timer_reg - 32'h1;
        end
      endcase
    end
  end

  // Page base held for the whole walk over the buffer
  always_ff @(posedge clk_sys) begin
    if (!resetn)
      page_reg <= 16'h0000;
    else if (opProg)
      page_reg <= lnkAddr[23:8];
  end

  // One array write per page offset actually sent
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      progValid <= 1'b0;
      progAddr <= 24'h000000;
      progData <= 8'h00;
    end else begin
      progValid <= (state_reg == SFW_PROG) & bufMask[progIdx_reg];
      progAddr <= {page_reg, progIdx_reg};
      progData <= bufByte;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      eraseValid <= 1'b0;
      eraseKind <= SFW_ER_SECTOR;
      eraseAddr <= 24'h000000;
    end else begin
      eraseValid <= opErase | opChip;
      if (opErase || opChip) begin
        eraseKind <= kindNext;
        eraseAddr <= lnkAddr & eraseMask;
      end
    end
  end

  // Latch drops as the cycle starts, well before it ends
  always_ff @(posedge clk_sys) begin
    if (!resetn)
      wel_reg <= 1'b0;
    else if (opWel)
      wel_reg <= 1'b1;
    else if (opWrd || opProg || opErase || opChip)
      wel_reg <= 1'b0;
  end

  // Power-down needs the delay; deselect alone never enters it
  always_ff @(posedge clk_sys) begin
    if (!resetn)
      dpd_reg <= 1'b0;
    else if (state_reg == SFW_DPWAIT && timer_reg == 32'h0)
      dpd_reg <= 1'b1;
    else if (opRel)
      dpd_reg <= 1'b0;
  end

  // Wrap bits persist until the next setting frame
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wrapDis_reg <= `SFW_WRAP_DIS_RST;
      wrapLen_reg <= `SFW_WRAP_LEN_RST;
    end else if (opWrap) begin
      wrapDis_reg <= lnkLast[`SFW_WRAP_DIS_POS];
      wrapLen_reg <= lnkLast[`SFW_WRAP_LEN_POS +: 2];
    end
  end

  // Read address walker for all reads; it wraps on the quad read path only
  always_ff @(posedge clk_sys) begin
    if (!resetn)
      readAddr_reg <= 24'h000000;
    else if (readLoad)
      readAddr_reg <= readStartAddr;
    else if (readStep)
      readAddr_reg <= readNext(readAddr_reg, readQuad & ~wrapDis_reg,
                               wrapLen_reg);
  end

  assign writeInProgress = busy;
  assign writeEnableLatch = wel_reg;
  assign deepPowerDown = dpd_reg;
  assign wrapDisableBit = wrapDis_reg;
  assign wrapLengthSel = wrapLen_reg;
  assign readAddr = readAddr_reg;

endmodule // sfw_flash_seq

`default_nettype wire

// ===== rtl/sfw_defines.svh
// Opcodes, frame lengths, field positions and timing figures
`ifndef SFW_DEFINES_SVH
`define SFW_DEFINES_SVH

`define SFW_OP_WR_ENABLE 8'h06
`define SFW_OP_WR_DISABLE 8'h04
`define SFW_OP_WRAP_SET 8'h77
`define SFW_OP_PROGRAM 8'h02
`define SFW_OP_SECTOR 8'h20
`define SFW_OP_BLOCK32 8'h52
`define SFW_OP_BLOCK64 8'hD8
`define SFW_OP_CHIP_A 8'h60
`define SFW_OP_CHIP_B 8'hC7
`define SFW_OP_POWER_DOWN 8'hB9
`define SFW_OP_RELEASE 8'hAB

// Frame lengths in whole bytes, opcode included
`define SFW_LEN_OPCODE 6'h01
`define SFW_LEN_ADDR 6'h04
`define SFW_LEN_WRAP 6'h05
`define SFW_LEN_MAX 6'h3F
`define SFW_BYTE_ADDR_LO 6'h03

`define SFW_WRAP_DIS_POS 4
`define SFW_WRAP_LEN_POS 5
`define SFW_WRAP_DIS_RST 1'b1
`define SFW_WRAP_LEN_RST 2'h0
`define SFW_WRAP_BASE 8'h08

`define SFW_SECTOR_MASK 24'hFFF000
`define SFW_BLOCK32_MASK 24'hFF8000
`define SFW_BLOCK64_MASK 24'hFF0000
`define SFW_BLOCK_POS 16
`define SFW_BLOCK_COUNT 4'h8
`define SFW_BLOCK_HALF 3'h4

`define SFW_CLK_MHZ 25
`define SFW_T_PP_US 700
`define SFW_T_SE_US 100000
`define SFW_T_BE_US 500000
`define SFW_T_CE_US 4000000
`define SFW_T_DP_US 3

`endif

// ===== rtl/sfw_pkg.sv
// Types shared by the flash sequencer files
package sfw_pkg;

  typedef enum logic [1:0] {
    SFW_IDLE = 2'h0,
    SFW_PROG = 2'h1,
    SFW_BUSY = 2'h3,
    SFW_DPWAIT = 2'h2
  } sfw_state_type;

  typedef enum logic [1:0] {
    SFW_ER_SECTOR = 2'h0,
    SFW_ER_BLOCK32 = 2'h1,
    SFW_ER_BLOCK64 = 2'h2,
    SFW_ER_CHIP = 2'h3
  } sfw_erase_type;

endpackage

// ===== rtl/sfw_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none

module sfw_sync (
  input wire logic clk,
  input wire logic din,
  output logic dout
);

  logic meta_reg;

  always_ff @(posedge clk) begin
    meta_reg <= din;
    dout <= meta_reg;
  end

endmodule // sfw_sync

`default_nettype wire

// ===== rtl/sfw_link_rx.sv
// Serial-clock side: shifter, frame fields, page buffer, ID out
`timescale 1ns/1ps
`default_nettype none
`include "sfw_defines.svh"

module sfw_link_rx #(
  // Arbitrary identification value
  parameter logic [7:0] DEV_ID = 8'h5A
) (
  input wire logic sclk,
  input wire logic csN,
  input wire logic si,
  input wire logic busySys,
  input wire logic [7:0] bufIdx,
  output logic [7:0] opcode,
  output logic [23:0] addr,
  output logic [7:0] lastByte,
  output logic [2:0] bitPos,
  output logic [5:0] byteCnt,
  output logic [255:0] bufMask,
  output logic [7:0] bufByte,
  output logic soOut,
  output logic soOe
);

  logic [6:0] shift_reg;
  logic [7:0] pgPtr_reg;
  logic [7:0] mem_reg [256];
  logic [7:0] inByte;
  logic busyLink;
  logic byteDone;
  logic storeData;
  logic [2:0] bitCnt_reg;
  logic [5:0] byteCnt_reg;

  sfw_sync u_busy_sync (.clk(sclk), .din(busySys), .dout(busyLink));

  assign inByte = {shift_reg, si};
  assign byteDone = (bitCnt_reg == 3'h7);
  // Buffer frozen while a program cycle reads it
  assign storeData = byteDone & (opcode == `SFW_OP_PROGRAM) &
                     (byteCnt_reg >= `SFW_LEN_ADDR) & ~busyLink;
  assign bufByte = mem_reg[bufIdx];

  // Frame counters restart while deselected; clock may be stopped
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      bitCnt_reg <= 3'h0;
      byteCnt_reg <= 6'h00;
    end else begin
      bitCnt_reg <= bitCnt_reg + 3'h1;
      if (byteDone && byteCnt_reg != `SFW_LEN_MAX)
        byteCnt_reg <= byteCnt_reg + 6'h01;
    end
  end

  // Length copy survives deselect; the cleared counters cannot be read late
  always_ff @(posedge sclk) begin
    bitPos <= bitCnt_reg + 3'h1;
    if (byteDone && byteCnt_reg != `SFW_LEN_MAX)
      byteCnt <= byteCnt_reg + 6'h01;
    else
      byteCnt <= byteCnt_reg;
  end

  // Fields stay static after the frame for the system side
  always_ff @(posedge sclk) begin
    shift_reg <= inByte[6:0];
    if (byteDone) begin
      lastByte <= inByte;
      if (byteCnt_reg == 6'h00)
        opcode <= inByte;
      if (byteCnt_reg != 6'h00 && byteCnt_reg < `SFW_LEN_ADDR)
        addr <= {addr[15:0], inByte};
      if (byteCnt_reg == `SFW_BYTE_ADDR_LO)
        pgPtr_reg <= inByte;
    end
    if (storeData) begin
      mem_reg[pgPtr_reg] <= inByte;
      pgPtr_reg <= pgPtr_reg + 8'h01;
      if (byteCnt_reg == `SFW_LEN_ADDR)
        bufMask <= 256'(1) << pgPtr_reg;
      else
        bufMask <= bufMask | (256'(1) << pgPtr_reg);
    end
  end

  // ID bits leave on the falling edge after three dummy bytes
  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin
      soOe <= 1'b0;
      soOut <= 1'b0;
    end else begin
      soOe <= (opcode == `SFW_OP_RELEASE) && (byteCnt_reg >= `SFW_LEN_ADDR);
      soOut <= DEV_ID[~bitCnt_reg];
    end
  end

endmodule // sfw_link_rx

`default_nettype wire

// ===== verif/sfw_host_model.sv
// Host model driving the serial link pins of the sequencer
`timescale 1ns/1ps
`default_nettype none

module sfw_host_model (
  output logic csN,
  output logic sclk,
  output logic si
);
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end

  // Bytes go out MSB first; dropBits trims the tail to break framing
  task automatic frame(input logic [7:0] q[$], input int dropBits);
    int n;
    n = q.size() * 8 - dropBits;
    csN = 1'b0;
    for (int i = 0; i < n; i++) begin
      si = q[i / 8][7 - i % 8];
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
    end
    #3 csN = 1'b1;
    // Released line must not look like a held bit
    si = ~si;
    #200;
  endtask
endmodule // sfw_host_model

`default_nettype wire

// ===== verif/sfw_flash_seq_properties.sv
// Concurrent checks on the sequencer top-level ports
`timescale 1ns/1ps
`default_nettype none

module sfw_flash_seq_properties
  import sfw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [4:0] protectBits,
  input wire logic writeInProgress,
  input wire logic writeEnableLatch,
  input wire logic deepPowerDown,
  input wire logic wrapDisableBit,
  input wire logic [1:0] wrapLengthSel,
  input wire logic progValid,
  input wire logic [23:0] progAddr,
  input wire logic eraseValid,
  input var sfw_erase_type eraseKind,
  input wire logic [23:0] eraseAddr,
  input wire logic readQuad,
  input wire logic readLoad,
  input wire logic [23:0] readStartAddr,
  input wire logic readStep,
  input wire logic [23:0] readAddr
);
  logic [23:0] secMask;
  logic [23:0] nextRead;

  always_comb begin
    secMask = 24'hFFFFFF;
    if (readQuad && !wrapDisableBit) begin
      secMask = (24'h000008 << wrapLengthSel) - 24'h000001;
    end
    nextRead = (readAddr & ~secMask) | ((readAddr + 24'h000001) & secMask);
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence sEraseGo;
    eraseValid && writeInProgress && !writeEnableLatch;
  endsequence

  AST_ERASE_START: assert property (eraseValid |-> sEraseGo)
    else $error("erase pulse without busy or with latch set");
  AST_ERASE_HOLD: assert property (sEraseGo |=> (!eraseValid && writeInProgress) [*4])
    else $error("erase pulse too long or busy dropped early");
  AST_SECTOR_ALIGN: assert property (eraseValid && eraseKind == SFW_ER_SECTOR |-> eraseAddr[11:0] == 12'h000)
    else $error("sector erase base not aligned");
  AST_BLOCK32_ALIGN: assert property (eraseValid && eraseKind == SFW_ER_BLOCK32 |-> eraseAddr[14:0] == 15'h0000)
    else $error("32KB erase base not aligned");
  AST_BLOCK64_ALIGN: assert property (eraseValid && eraseKind == SFW_ER_BLOCK64 |-> eraseAddr[15:0] == 16'h0000)
    else $error("64KB erase base not aligned");
  AST_CHIP_UNPROT: assert property (eraseValid && eraseKind == SFW_ER_CHIP |-> protectBits[2:0] == 3'h0 && eraseAddr == 24'h000000)
    else $error("chip erase under protection");
  AST_PROG_PAGE: assert property (progValid && $past(progValid) |-> progAddr[23:8] == $past(progAddr[23:8]))
    else $error("program left its page");
  AST_PROG_BUSY: assert property (progValid |-> writeInProgress && !writeEnableLatch)
    else $error("program write while idle");
  AST_WIP_RISE: assert property ($rose(writeInProgress) |-> !writeEnableLatch)
    else $error("latch still set when busy starts");
  AST_NO_DP_BUSY: assert property (!(writeInProgress && deepPowerDown))
    else $error("power-down while busy");
  AST_READ_STEP: assert property (readStep && !readLoad |=> readAddr == $past(nextRead))
    else $error("read address step wrong");
  AST_READ_LOAD: assert property (readLoad |=> readAddr == $past(readStartAddr))
    else $error("read address load wrong");
endmodule // sfw_flash_seq_properties

bind sfw_flash_seq sfw_flash_seq_properties chk (.clk_sys(clk_sys), .resetn(resetn),
  .protectBits(protectBits), .writeInProgress(writeInProgress),
  .writeEnableLatch(writeEnableLatch), .deepPowerDown(deepPowerDown),
  .wrapDisableBit(wrapDisableBit), .wrapLengthSel(wrapLengthSel), .progValid(progValid),
  .progAddr(progAddr), .eraseValid(eraseValid), .eraseKind(eraseKind), .eraseAddr(eraseAddr),
  .readQuad(readQuad), .readLoad(readLoad), .readStartAddr(readStartAddr),
  .readStep(readStep), .readAddr(readAddr));

`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import sfw_pkg::*;
;
  typedef struct {
    logic [7:0] op;
    logic [23:0] addr;
    logic [4:0] prot;
    logic ok;
    sfw_erase_type kind;
    logic [23:0] base;
  } sfw_row_type;
  logic clk_sys, sclk, csN, si, writeInProgress, writeEnableLatch, deepPowerDown;
  logic resetn = 1'b0;
  logic readQuad = 1'b0;
  logic readLoad = 1'b0;
  logic readStep = 1'b0;
  logic [4:0] protectBits = 5'h00;
  logic [23:0] readStartAddr = 24'h000000;
  logic [23:0] readAddr, progAddr, eraseAddr, gotBase;
  logic wrapDisableBit, progValid, eraseValid;
  logic [1:0] wrapLengthSel;
  logic [7:0] progData;
  sfw_erase_type eraseKind, gotKind;
  logic [7:0] mem [256];
  logic [7:0] expMem [256];
  int bad_count = 0;
  int n_compared = 0;
  int nErase = 0;
  int nProg = 0;
  sfw_row_type rows [8] = '{
    '{8'h20, 24'h012345, 5'h00, 1'b1, SFW_ER_SECTOR, 24'h012000},
    '{8'h52, 24'h01ABCD, 5'h00, 1'b1, SFW_ER_BLOCK32, 24'h018000},
    '{8'hD8, 24'h03FFFF, 5'h00, 1'b1, SFW_ER_BLOCK64, 24'h030000},
    '{8'h60, 24'h000000, 5'h00, 1'b1, SFW_ER_CHIP, 24'h000000},
    '{8'hC7, 24'h000000, 5'h00, 1'b1, SFW_ER_CHIP, 24'h000000},
    '{8'hC7, 24'h000000, 5'h01, 1'b0, SFW_ER_CHIP, 24'h000000},
    '{8'hD8, 24'h070000, 5'h01, 1'b0, SFW_ER_BLOCK64, 24'h070000},
    '{8'h20, 24'h010000, 5'h01, 1'b1, SFW_ER_SECTOR, 24'h010000}};

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  sfw_flash_seq #(.PROG_CYCLES(20), .SECTOR_CYCLES(60), .BLOCK_CYCLES(20),
    .CHIP_CYCLES(20)) dut (.clk_sys(clk_sys), .resetn(resetn), .sclk(sclk), .csN(csN),
    .si(si), .soOut(), .soOe(), .protectBits(protectBits), .writeInProgress(writeInProgress),
    .writeEnableLatch(writeEnableLatch), .deepPowerDown(deepPowerDown),
    .wrapDisableBit(wrapDisableBit), .wrapLengthSel(wrapLengthSel), .progValid(progValid),
    .progAddr(progAddr), .progData(progData), .eraseValid(eraseValid), .eraseKind(eraseKind),
    .eraseAddr(eraseAddr), .readQuad(readQuad), .readLoad(readLoad),
    .readStartAddr(readStartAddr), .readStep(readStep), .readAddr(readAddr));
  sfw_host_model host (.csN(csN), .sclk(sclk), .si(si));

  always @(posedge clk_sys) begin
    if (eraseValid === 1'b1) begin
      nErase++;
      gotKind = eraseKind;
      gotBase = eraseAddr;
    end
    if (progValid === 1'b1) begin
      nProg++;
      mem[progAddr[7:0]] = progData;
    end
  end

  task automatic final_report();
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic waitIdle();
    int k;
    k = 0;
    repeat (4) @(posedge clk_sys);
    while (writeInProgress !== 1'b0) begin
      @(posedge clk_sys);
      k++;
      if (k > 2000) begin
        bad_count++;
        final_report();
      end
    end
  endtask

  // Program at page offset lo; later bytes at one offset win
  task automatic prog(input logic [7:0] lo, input int n);
    logic [7:0] q[$];
    q = '{8'h02, 8'h00, 8'h12, lo};
    for (int i = 0; i < n; i++) begin
      q.push_back(8'(i) ^ 8'hA5);
      expMem[(lo + i) % 256] = 8'(i) ^ 8'hA5;
    end
    nProg = 0;
    host.frame('{8'h06}, 0);
    host.frame(q, 0);
    waitIdle();
    check(nProg, (n > 256) ? 256 : n);
    for (int i = 0; i < n; i++) check(mem[(lo + i) % 256], expMem[(lo + i) % 256]);
  endtask

  task automatic readCheck(input logic quad, input logic [23:0] start, input logic [23:0] exp);
    @(posedge clk_sys);
    readQuad <= quad;
    readStartAddr <= start;
    readLoad <= 1'b1;
    @(posedge clk_sys);
    readLoad <= 1'b0;
    readStep <= 1'b1;
    @(posedge clk_sys);
    readStep <= 1'b0;
    @(posedge clk_sys);
    check(readAddr, exp);
  endtask

  initial begin
    logic [7:0] w;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    check({writeInProgress, writeEnableLatch, deepPowerDown, wrapDisableBit, wrapLengthSel,
      progValid, eraseValid}, 8'h10);
    foreach (rows[i]) begin
      @(posedge clk_sys);
      protectBits <= rows[i].prot;
      nErase = 0;
      host.frame('{8'h06}, 0);
      check(writeEnableLatch, 1'b1);
      if (rows[i].op == 8'h60 || rows[i].op == 8'hC7) host.frame('{rows[i].op}, 0);
      else host.frame('{rows[i].op, rows[i].addr[23:16], rows[i].addr[15:8], rows[i].addr[7:0]}, 0);
      waitIdle();
      check(nErase, rows[i].ok);
      if (rows[i].ok) check({gotKind, gotBase}, {rows[i].kind, rows[i].base});
    end
    // Refusals: no latch, short address, broken last byte
    nErase = 0;
    nProg = 0;
    host.frame('{8'h04}, 0);
    host.frame('{8'h20, 8'h00, 8'h10, 8'h00}, 0);
    check({nErase[30:0], writeInProgress}, 32'h0);
    host.frame('{8'h06}, 0);
    host.frame('{8'h20, 8'h00, 8'h10}, 0);
    host.frame('{8'h02, 8'h00, 8'h10, 8'h00, 8'hAA}, 3);
    waitIdle();
    check(nErase + nProg, 32'h0);
    prog(8'hFE, 3);
    prog(8'hFE, 258);
    // Power-down and write enable arriving while an erase runs
    host.frame('{8'h06}, 0);
    host.frame('{8'h20, 8'h00, 8'h20, 8'h00}, 0);
    host.frame('{8'hB9}, 0);
    host.frame('{8'h06}, 0);
    waitIdle();
    repeat (100) @(posedge clk_sys);
    check({nErase[30:0], deepPowerDown}, 32'h2);
    host.frame('{8'hB9, 8'h00}, 7);
    repeat (100) @(posedge clk_sys);
    check(deepPowerDown, 1'b0);
    host.frame('{8'hB9}, 0);
    check(deepPowerDown, 1'b0);
    repeat (80) @(posedge clk_sys);
    check(deepPowerDown, 1'b1);
    host.frame('{8'h06}, 0);
    check(writeEnableLatch, 1'b0);
    host.frame('{8'hAB}, 0);
    check(deepPowerDown, 1'b0);
    for (int L = 0; L < 5; L++) begin
      w = (L == 4) ? 8'h10 : {1'b0, 2'(L), 5'h00};
      host.frame('{8'h77, 8'h00, 8'h00, 8'h00, w}, 0);
      check({wrapDisableBit, wrapLengthSel}, (L == 4) ? 3'h4 : 3'(L));
      if (L == 4) readCheck(1'b1, 24'h123407, 24'h123408);
      else readCheck(1'b1, 24'h123400 | ((24'h000008 << L) - 24'h000001), 24'h123400);
    end
    host.frame('{8'h77, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
    readCheck(1'b0, 24'h123407, 24'h123408);
    final_report();
  end
endmodule // tb_top

`default_nettype wire
